// file: core/port_irq_pkg.sv
// Package with register offsets, field positions and state types for the port interrupt block.
package port_irq_pkg;

  // Register byte offsets within the port window.
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_CMD_STATUS = 8'h18;

  // Writable enable bits; bits 21:8 and 25 are reserved and read as zero.
  localparam logic [31:0] IRQ_EN_WMASK = 32'hfdc0_00ff;
  // Position of the mechanical presence enable.
  localparam int MECH_EN_BIT = 7;
  // Position of the cold presence enable.
  localparam int COLD_EN_BIT = 31;
  // Command register field positions.
  localparam int RUN_BIT = 0;
  localparam int FRE_BIT = 4;
  // Reset value of both registers.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Number of command slots.
  localparam int SLOT_COUNT = 32;

  // Register access request from the host side.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Command engine states.
  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_RUN,
    ENG_STOP
  } eng_state_t;

endpackage : port_irq_pkg

// file: core/port_irq_start.sv
// Port interrupt enable, interrupt combine and command-engine run control.
//
// Operation
// - Received-FIS flags 0..3 raise interrupt when enabled.
// - Unknown FIS flag raises interrupt when enabled.
// - Descriptor done flag raises interrupt when enabled.
// - Port change flag raises interrupt when enabled.
// - Mechanical presence flag raises interrupt when enabled.
// - No presence switch: bit 7 reads zero.
// - PHY ready change raises interrupt when enabled.
// - Wrong port multiplier raises interrupt when enabled.
// - Overflow flag raises interrupt when enabled.
// - Nonfatal link error raises interrupt when enabled.
// - Fatal link error raises interrupt when enabled.
// - Host bus data error raises interrupt when enabled.
// - Host bus fatal error raises interrupt when enabled.
// - Task file error raises interrupt when enabled.
// - Cold presence flag raises interrupt when enabled.
// - No cold detect: bit 31 reads zero.
// - Process commands only while run bit set.
// - Run rising edge restarts at slot zero.
// - Run falling: clear issue vector once idle.
// - Flags clear by writing one elsewhere.
// - Post received frames only while receive enabled.
`timescale 1ns/1ps
module port_irq_start
  import port_irq_pkg::*;
#(
  parameter bit HAS_MECH_SWITCH = 1'b1,
  parameter bit HAS_COLD_DETECT = 1'b1,
  parameter int SLOTS = SLOT_COUNT
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire reg_req_t req_i,
  input wire logic global_interrupt_enable_i,
  input wire logic [31:0] port_flags_i,
  input wire logic [SLOTS-1:0] issue_set_i,
  input wire logic [SLOTS-1:0] slot_done_i,
  input wire logic engine_idle_i,
  output logic [31:0] rdata_o,
  output logic port_irq_o,
  output logic engine_active_o,
  output logic restart_pulse_o,
  output logic fis_post_allow_o,
  output logic [SLOTS-1:0] command_issue_vector_o
);

  // Effective write mask with unsupported presence enables forced read-only.
  localparam logic [31:0] EN_MASK = IRQ_EN_WMASK
    & ~({31'h0, !HAS_MECH_SWITCH} << MECH_EN_BIT)
    & ~({31'h0, !HAS_COLD_DETECT} << COLD_EN_BIT);

  // Stored interrupt enables.
  logic [31:0] irq_en_r;
  // Run bit and receive enable.
  logic run_r;
  logic fre_r;
  // Engine state and issue vector.
  eng_state_t state_r;
  logic [SLOTS-1:0] ci_r;
  // Interrupt output register.
  logic irq_r;
  // Read data register.
  logic [31:0] rdata_r;
  // Restart pulse register.
  logic restart_r;
  // Write strobes.
  logic wr_en;
  logic wr_cmd;
  // Combined pending conditions.
  logic [31:0] pending;

  assign wr_en = req_i.wr && (req_i.addr == OFS_IRQ_ENABLE);
  assign wr_cmd = req_i.wr && (req_i.addr == OFS_CMD_STATUS);

  // Enable register; reserved and unsupported bits never store.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_en_r <= REG_RESET;
    end else if (wr_en) begin
      irq_en_r <= req_i.wdata & EN_MASK;
    end
  end

  // Per-bit qualification of each flag by its enable.
  assign pending = irq_en_r & port_flags_i & EN_MASK;

  // Interrupt is a level: it stays up while the global enable and any pair stay set, and software
  // removes it by clearing the flag, which lives in the neighbouring block.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= global_interrupt_enable_i && (|pending);
    end
  end

  // Run and receive enable bits of the command register.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      run_r <= 1'b0;
      fre_r <= 1'b0;
    end else if (wr_cmd) begin
      // The run bit is taken as written; ordering against receive enable
      // is software's duty, so the block does not second-guess it.
      // software ordering
      run_r <= req_i.wdata[RUN_BIT];
      fre_r <= req_i.wdata[FRE_BIT];
    end
  end

  // Engine state: runs while the run bit is one, drains to idle on stop.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ENG_IDLE;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      case (state_r)
        ENG_IDLE: begin
          if (run_r) begin
            state_r <= ENG_RUN;
            restart_r <= 1'b1;
          end
        end
        ENG_RUN: begin
          if (!run_r) begin
            state_r <= ENG_STOP;
          end
        end
        ENG_STOP: begin
          if (engine_idle_i) begin
            state_r <= ENG_IDLE;
          end
        end
        default: begin
          state_r <= ENG_IDLE;
        end
      endcase
    end
  end

  // Issue vector; set by issue wins over completion in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ci_r <= '0;
    end else if (state_r == ENG_STOP && engine_idle_i) begin
      ci_r <= '0;
    end else begin
      ci_r <= (ci_r & ~slot_done_i) | issue_set_i;
    end
  end

  // Register read path, one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= REG_RESET;
    end else if (req_i.rd) begin
      case (req_i.addr)
        OFS_IRQ_ENABLE: rdata_r <= irq_en_r;
        OFS_CMD_STATUS: begin
          rdata_r <= REG_RESET;
          rdata_r[RUN_BIT] <= run_r;
          rdata_r[FRE_BIT] <= fre_r;
        end
        default: rdata_r <= REG_RESET;
      endcase
    end
  end

  assign rdata_o = rdata_r;
  assign port_irq_o = irq_r;
  assign engine_active_o = (state_r == ENG_RUN);
  assign restart_pulse_o = restart_r;
  assign fis_post_allow_o = fre_r;
  assign command_issue_vector_o = ci_r;

  // Interrupt follows the gated pending set one cycle later.
  property p_irq_follows;
    @(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> (port_irq_o == $past(global_interrupt_enable_i && (|pending)));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

  // No interrupt without the global enable.
  property p_irq_gated;
    @(posedge clk_i) disable iff (!reset_n_i)
    !global_interrupt_enable_i |=> !port_irq_o;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without global");

  // Reserved enable bits stay zero.
  property p_reserved_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (irq_en_r & ~IRQ_EN_WMASK) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

  // Unsupported presence enables stay zero.
  property p_presence_ro;
    @(posedge clk_i) disable iff (!reset_n_i)
    (irq_en_r & ~EN_MASK) == '0;
  endproperty
  a_presence_ro: assert property (p_presence_ro) else $error("presence ro set");

  // Starting from idle yields a restart pulse and run state next cycle.
  sequence s_start;
    state_r == ENG_IDLE && run_r;
  endsequence
  property p_start;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_start |=> restart_pulse_o && engine_active_o;
  endproperty
  a_start: assert property (p_start) else $error("no restart");

  // Engine is never active while run bit low for two cycles.
  property p_no_run;
    @(posedge clk_i) disable iff (!reset_n_i)
    !run_r [*2] |-> !engine_active_o;
  endproperty
  a_no_run: assert property (p_no_run) else $error("active while stopped");

  // Stop with idle clears the issue vector.
  property p_stop_clear;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_r == ENG_STOP && engine_idle_i) |=> command_issue_vector_o == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("vector kept");

  // Receive posting follows the written enable.
  property p_fre;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_cmd |=> fis_post_allow_o == $past(req_i.wdata[FRE_BIT]);
  endproperty
  a_fre: assert property (p_fre) else $error("fre mismatch");

endmodule : port_irq_start

// file: tb/drive_model.sv
// Drive-side model that completes issued slots and reports controller idle.
`timescale 1ns/1ps
module drive_model #(
  parameter int SLOTS = 32,
  parameter int IDLE_DLY = 3
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic engine_active_i,
  input wire logic [SLOTS-1:0] vector_i,
  output logic [SLOTS-1:0] slot_done_o,
  output logic engine_idle_o
);
  // Cycles since the engine stopped; idle waits out a drain delay, like a slow drive.
  int quiet;
  // Slots finish lowest first, one at a time, so some are still pending at a stop.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      quiet <= 0;
      slot_done_o <= '0;
      engine_idle_o <= 1'b1;
    end else begin
      quiet <= engine_active_i ? 0 : quiet + 1;
      slot_done_o <= engine_active_i ? (vector_i & (~vector_i + 1'b1)) : '0;
      engine_idle_o <= !engine_active_i && quiet >= IDLE_DLY;
    end
  end
endmodule : drive_model

// file: tb/sata_port_irq_enable_and_start_test.sv
// Self-checking bench for the port interrupt enable and run control block.
`timescale 1ns/1ps
module sata_port_irq_enable_and_start_test;
  import port_irq_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  reg_req_t req_i = '0;
  logic gie = 1'b0;
  logic [31:0] flags = '0;
  logic [31:0] iset = '0;
  logic [31:0] done, rdata, en, vec;
  logic irq, active, restart, fis_ok, idle;
  int miscompares = 0;
  int checked = 0;
  int n;
  // Free-running core clock, 40 ns period.
  always #20 clk_i = ~clk_i;
  port_irq_start port_irq_start_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
    .global_interrupt_enable_i(gie), .port_flags_i(flags), .issue_set_i(iset),
    .slot_done_i(done), .engine_idle_i(idle), .rdata_o(rdata), .port_irq_o(irq),
    .engine_active_o(active), .restart_pulse_o(restart), .fis_post_allow_o(fis_ok),
    .command_issue_vector_o(vec));
  drive_model drive_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .engine_active_i(active),
    .vector_i(vec), .slot_done_o(done), .engine_idle_o(idle));
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One register access, held for exactly the taking edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_i <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    req_i <= '0;
    #1;
  endtask : bus
  // Lets the registered interrupt follow its cause.
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  // Expected interrupt from enables, flags and the global gate.
  function automatic logic exp_irq(input logic [31:0] e, input logic [31:0] f, input logic g);
    return g & |(e & f & IRQ_EN_WMASK);
  endfunction : exp_irq
  initial begin
    void'($urandom(32'h84d6c939));
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(0, OFS_IRQ_ENABLE, 0);
    check(rdata, REG_RESET);
    bus(1, OFS_IRQ_ENABLE, 32'hffff_ffff);
    bus(0, OFS_IRQ_ENABLE, 0);
    check(rdata, IRQ_EN_WMASK);
    bus(1, 8'h1c, 32'hffff_ffff);
    bus(0, 8'h1c, 0);
    check(rdata, 32'h0);
    // Each enable against its own flag, then with the global gate shut.
    for (int i = 0; i < 32; i++) begin
      bus(1, OFS_IRQ_ENABLE, 32'h1 << i);
      @(posedge clk_i);
      flags <= 32'h1 << i;
      gie <= 1'b1;
      settle();
      check(irq, IRQ_EN_WMASK[i]);
      gie <= 1'b0;
      settle();
      check(irq, 1'b0);
    end
    // Random mixes; each pass replaces the flags with a new random set, never all zero on purpose.
    for (int k = 0; k < 40; k++) begin
      en = $urandom();
      bus(1, OFS_IRQ_ENABLE, en);
      @(posedge clk_i);
      flags <= $urandom() & $urandom();
      gie <= $urandom_range(1, 0);
      settle();
      check(irq, exp_irq(en, flags, gie));
    end
    bus(1, OFS_CMD_STATUS, 32'h10);
    check(fis_ok, 1'b1);
    bus(1, OFS_CMD_STATUS, 32'h11);
    n = 0;
    while (restart !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(restart, 1'b1);
    check(active, 1'b1);
    @(posedge clk_i);
    iset <= 32'hf0f0_0003;
    @(posedge clk_i);
    iset <= '0;
    // Stop with slots still pending; the vector must clear once idle.
    bus(1, OFS_CMD_STATUS, 32'h10);
    @(posedge clk_i);
    #1;
    check(active, 1'b0);
    n = 0;
    while (vec !== '0 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(vec, 32'h0);
    check(idle, 1'b1);
    bus(0, OFS_CMD_STATUS, 0);
    check(rdata, 32'h10);
    complete_run();
  end
endmodule : sata_port_irq_enable_and_start_test
